// *** core/sync_serial_bridge_port.sv ***
// Purpose: instrument side of the four-line synchronous bridge port
// Assumes: host clock line is slow against clock and is sampled, not used as a clock
// Notes:   the conversion pacing counter can be shortened for simulation

`timescale 1ns/1ns

module sync_serial_bridge_port #(
	parameter int unsigned CONV_PERIOD_CYCLES = bridge_port_pkg::CONV_CYCLES
) (
	// clock and reset
	input  wire logic                                    clock,
	input  wire logic                                    sys_rst,
	// link pins from the host
	input  wire logic                                    host_clock_line,
	input  wire logic                                    host_data_line,
	// link pins to the host
	output logic                                         instrument_data_line,
	output logic                                         result_ready_line,
	// address switch
	input  wire logic [bridge_port_pkg::SWITCH_BITS-1:0] device_select_address,
	// converter side
	output logic                                         conversion_start,
	input  wire logic                                    result_valid,
	input  wire logic [bridge_port_pkg::BCD_BITS-1:0]    result_bcd,
	// front panel indicator state
	input  wire logic [bridge_port_pkg::IND_BITS-1:0]    panel_indicators,
	// applied configuration
	output logic      [bridge_port_pkg::DATA_BITS-1:0]   applied_config,
	output logic                                         config_update
);

	import bridge_port_pkg::*;

	// ****************************************
	// state record
	// ****************************************
	typedef struct packed {
		port_state_t            state;
		logic                   clk_prev;
		logic                   data_prev;
		logic [1:0]             toggle_cnt;
		logic                   strobe_done;
		logic [ADDR_BITS-1:0]   addr_shift;
		logic [DATA_BITS-1:0]   rx_shift;
		logic [DATA_BITS-1:0]   tx_shift;
		logic [DATA_BITS-1:0]   config_now;
		logic                   config_pulse;
		logic [BCD_BITS-1:0]    result_hold;
		logic                   ready;
		logic                   data_out;
		logic [CONV_CNT_W-1:0]  conv_cnt;
		logic                   conv_pulse;
	} port_regs_t;

	port_regs_t r;
	port_regs_t next_r;

	// ****************************************
	// pin synchronisers
	// ****************************************
	localparam int unsigned SYNC_W = SWITCH_BITS + 2;

	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_sync;
	logic              host_clk_s;
	logic              host_data_s;
	logic [SWITCH_BITS-1:0] switch_s;

	assign pins_raw = {device_select_address, host_data_line, host_clock_line};

	pin_sync #(
		.WIDTH   (SYNC_W)
	) u_pin_sync (
		.clock   (clock),
		.pin_in  (pins_raw),
		.pin_out (pins_sync)
	);

	assign host_clk_s  = pins_sync[0];
	assign host_data_s = pins_sync[1];
	assign switch_s    = pins_sync[SYNC_W-1:2];

	// ****************************************
	// own address
	// ****************************************
	// an out-of-range switch setting of zero falls back to the factory address
	logic [SWITCH_BITS-1:0] own_addr;
	logic                   addr_match;

	assign own_addr   = (switch_s == ADDR_NONE) ? ADDR_FACTORY : switch_s;
	// full eight-bit compare keeps other addresses on a shared cable silent
	assign addr_match = (r.addr_shift == {4'h0, own_addr});

	// ****************************************
	// edge detection
	// ****************************************
	// the pins are sampled rather than used as clocks, so a slow or
	// stalled host clock costs nothing but time
	logic clk_rise;
	logic clk_low;
	logic data_rise;

	assign clk_rise  = host_clk_s & ~r.clk_prev;
	assign clk_low   = ~host_clk_s;
	assign data_rise = host_data_s & ~r.data_prev;

	// ****************************************
	// strobe detection
	// ****************************************
	// normal bits change data at most once per low clock, so three rises
	// under a low clock can only be a strobe
	logic toggle_count;
	logic toggle_last;
	logic strobe;

	assign toggle_count = clk_low & data_rise & ~r.strobe_done;
	assign toggle_last  = (r.toggle_cnt == STROBE_TOGGLES - 2'h1);
	assign strobe       = toggle_count & toggle_last;

	// ****************************************
	// transaction decode
	// ****************************************
	logic port_open;
	logic shift_bit;
	logic open_port;
	logic close_port;

	assign port_open  = (r.state == PORT_OPEN);
	assign shift_bit  = clk_rise & port_open;
	assign open_port  = strobe & ~port_open & addr_match;
	assign close_port = strobe & port_open;

	// ****************************************
	// shift paths
	// ****************************************
	// first character lands in the top bit after a full string
	logic [ADDR_BITS-1:0] addr_next;
	logic [DATA_BITS-1:0] rx_next;
	logic [DATA_BITS-1:0] tx_next;
	logic                 bit_out;

	assign addr_next = {r.addr_shift[ADDR_BITS-2:0], host_data_s};
	assign rx_next   = {r.rx_shift[DATA_BITS-2:0], host_data_s};
	assign tx_next   = {r.tx_shift[DATA_BITS-2:0], 1'b0};
	assign bit_out   = r.tx_shift[DATA_BITS-2];

	// ****************************************
	// response snapshot
	// ****************************************
	// taken at the address strobe, before any new bit arrives
	logic [DATA_BITS-1:0] snapshot;

	assign snapshot = {panel_indicators, r.result_hold};

	// ****************************************
	// configuration apply
	// ****************************************
	// the shifted string is copied only at the closing strobe, so a cut
	// transfer never reaches the applied configuration
	logic apply_config;

	assign apply_config = close_port;

	// ****************************************
	// ready line
	// ****************************************
	// a result in the same cycle as the closing strobe keeps ready high
	logic ready_set;
	logic ready_clear;

	assign ready_set   = result_valid;
	assign ready_clear = close_port;

	// ****************************************
	// conversion pacing
	// ****************************************
	// shortened by parameter in simulation; the default gives 0.4 s
	logic                  conv_wrap;
	logic [CONV_CNT_W-1:0] conv_inc;

	assign conv_wrap = (r.conv_cnt == CONV_CNT_W'(CONV_PERIOD_CYCLES - 1));
	assign conv_inc  = r.conv_cnt + 25'h000_0001;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_r              = r;
		next_r.clk_prev     = host_clk_s;
		next_r.data_prev    = host_data_s;
		next_r.config_pulse = 1'b0;
		next_r.conv_pulse   = 1'b0;

		// strobe counter restarts whenever the clock is high
		if (host_clk_s) begin
			next_r.toggle_cnt  = 2'h0;
			next_r.strobe_done = 1'b0;
		end else if (strobe) begin
			next_r.toggle_cnt  = 2'h0;
			next_r.strobe_done = 1'b1;
		end else if (toggle_count) begin
			next_r.toggle_cnt = r.toggle_cnt + 2'h1;
		end

		// no timer watches the link; pauses of any length are harmless
		if (clk_rise) begin
			next_r.addr_shift = addr_next;
			next_r.data_out   = 1'b0;
		end
		if (shift_bit) begin
			next_r.rx_shift = rx_next;
			next_r.tx_shift = tx_next;
			next_r.data_out = bit_out;
		end

		// port opens or closes only on a strobe
		if (strobe) begin
			unique case (r.state)
				PORT_CLOSED: begin
					next_r.data_out = 1'b0;
					if (open_port) begin
						next_r.state    = PORT_OPEN;
						next_r.rx_shift = CONFIG_RESET;
						next_r.tx_shift = snapshot;
						next_r.data_out = snapshot[DATA_BITS-1];
					end
				end
				PORT_OPEN: begin
					next_r.state    = PORT_CLOSED;
					next_r.data_out = 1'b0;
				end
			endcase
		end

		if (apply_config) begin
			next_r.config_now   = r.rx_shift;
			next_r.config_pulse = 1'b1;
		end

		// set wins over clear
		if (result_valid) begin
			next_r.result_hold = result_bcd;
		end
		if (ready_set) begin
			next_r.ready = 1'b1;
		end else if (ready_clear) begin
			next_r.ready = 1'b0;
		end

		if (conv_wrap) begin
			next_r.conv_cnt   = CONV_CNT_RESET;
			next_r.conv_pulse = 1'b1;
		end else begin
			next_r.conv_cnt = conv_inc;
		end

		// reset last, so it overrides everything above

		if (sys_rst) begin
			next_r             = '0;
			next_r.state       = PORT_CLOSED;
			next_r.config_now  = CONFIG_RESET;
			next_r.result_hold = RESULT_RESET;
			next_r.conv_cnt    = CONV_CNT_RESET;
			next_r.data_out    = 1'b0;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clock) begin
		r <= next_r;
	end

	// ****************************************
	// outputs
	// ****************************************
	// instrument data only goes high while ports are open, so wired sharing works
	assign instrument_data_line = r.data_out;
	assign result_ready_line    = r.ready;
	assign applied_config       = r.config_now;
	assign config_update        = r.config_pulse;
	assign conversion_start     = r.conv_pulse;

endmodule // sync_serial_bridge_port

// *** shared/bridge_port_pkg.sv ***
// Purpose: shared constants and types for the bridge serial port
// Assumes: 50 MHz system clock
// Notes:   the conversion cycle count derives from the time figures below

package bridge_port_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLOCK_HZ        = 50_000_000;
	localparam int unsigned CONV_PERIOD_MS  = 400;
	localparam int unsigned CONV_CYCLES     = (CLOCK_HZ / 1000) * CONV_PERIOD_MS;
	localparam int unsigned CONV_CNT_W      = 25;

	// ****************************************
	// string layout
	// ****************************************
	localparam int unsigned ADDR_BITS       = 8;
	localparam int unsigned DATA_BITS       = 48;
	localparam int unsigned IND_BITS        = 24;
	localparam int unsigned BCD_BITS        = 24;
	localparam int unsigned SWITCH_BITS     = 4;

	// ****************************************
	// address switch
	// ****************************************
	localparam logic [SWITCH_BITS-1:0] ADDR_FACTORY = 4'h1;
	localparam logic [SWITCH_BITS-1:0] ADDR_NONE    = 4'h0;

	// ****************************************
	// strobe pattern
	// ****************************************
	localparam logic [1:0] STROBE_TOGGLES   = 2'h3;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [DATA_BITS-1:0] CONFIG_RESET = 48'h0000_0000_0000;
	localparam logic [BCD_BITS-1:0]  RESULT_RESET = 24'h00_0000;
	localparam logic [CONV_CNT_W-1:0] CONV_CNT_RESET = 25'h000_0000;

	// ****************************************
	// port states
	// ****************************************
	typedef enum logic [1:0] {
		PORT_CLOSED = 2'b01,
		PORT_OPEN   = 2'b10
	} port_state_t;

endpackage

// *** core/pin_sync.sv ***
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: inputs are asynchronous to clock
// Notes:   first stage feeds only the second stage

`timescale 1ns/1ns

module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock
	input  wire logic             clock,
	// pins in and synchronised out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] stage_one;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clock) begin
				stage_one[i] <= pin_in[i];
				pin_out[i]   <= stage_one[i];
			end
		end
	endgenerate

endmodule // pin_sync

// *** bench/bridge_port_sva.sv ***
// Purpose: port checks for the bridge port
// Assumes: bound to the top module, latencies as handed over
// Notes:   pin edges reach the outputs within five cycles
`timescale 1ns/1ns
module bridge_port_sva
	import bridge_port_pkg::*;
#(
	parameter int unsigned CONV_PERIOD_CYCLES = 50
) (
	// clock and reset
	input wire logic                   clock,
	input wire logic                   sys_rst,
	// link
	input wire logic                   host_clock_line,
	input wire logic                   host_data_line,
	input wire logic                   instrument_data_line,
	input wire logic                   result_ready_line,
	// switch, converter, panel
	input wire logic [SWITCH_BITS-1:0] device_select_address,
	input wire logic                   conversion_start,
	input wire logic                   result_valid,
	input wire logic [BCD_BITS-1:0]    result_bcd,
	input wire logic [IND_BITS-1:0]    panel_indicators,
	// configuration
	input wire logic [DATA_BITS-1:0]   applied_config,
	input wire logic                   config_update
);
	// ****
	// helpers
	// ****
	logic [24:0] gap;
	logic        seen;
	logic [1:0]  prev;
	logic [5:0]  ev;
	// ev marks recent pin rises, the only legal cause of a data change
	always_ff @(posedge clock) begin
		prev <= {host_clock_line, host_data_line};
		ev   <= {ev[4:0], |({host_clock_line, host_data_line} & ~prev)};
		if (sys_rst || conversion_start) gap <= 25'h0;
		else gap <= gap + 25'h1;
		if (sys_rst) seen <= 1'b0;
		else if (conversion_start) seen <= 1'b1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	ready_set_a: assert property (result_valid |=> result_ready_line)
		else $error("ready not raised");
	ready_cause_a: assert property ($rose(result_ready_line) |-> $past(result_valid))
		else $error("ready rose alone");
	ready_drop_a: assert property ($fell(result_ready_line) |-> config_update)
		else $error("ready fell alone");
	config_hold_a: assert property (!config_update |-> $stable(applied_config))
		else $error("config moved without update");
	update_pulse_a: assert property (config_update |=> !config_update)
		else $error("update longer than one cycle");
	closed_quiet_a: assert property (config_update |-> !instrument_data_line)
		else $error("data line high at close");
	reset_state_a: assert property ($fell(sys_rst) |->
		!instrument_data_line && !result_ready_line && applied_config == CONFIG_RESET)
		else $error("bad state after reset");
	data_cause_a: assert property ($changed(instrument_data_line) |-> |ev[5:1])
		else $error("data line moved without pin edge");
	conv_gap_a: assert property (conversion_start && seen |-> gap == CONV_PERIOD_CYCLES - 1)
		else $error("conversion spacing wrong");
	conv_bound_a: assert property (gap <= CONV_PERIOD_CYCLES)
		else $error("conversion start missing");
endmodule // bridge_port_sva

// *** bench/bridge_host_model.sv ***
// Purpose: host driving the clock and data pins
// Assumes: half period of 80 ns on the host clock
// Notes:   data settles a half period before each rise
`timescale 1ns/1ns
module bridge_host_model (
	// to the device
	output logic      host_clock_line,
	output logic      host_data_line,
	// from the device
	input  wire logic instrument_data_line
);
	initial begin
		host_clock_line = 1'b0;
		host_data_line  = 1'b0;
	end
	task automatic shift(input logic [47:0] tx, input int n, output logic [47:0] rx);
		rx = 48'h0;
		for (int i = n - 1; i >= 0; i--) begin
			host_data_line = tx[i];
			#80;
			rx = {rx[46:0], instrument_data_line};
			host_clock_line = 1'b1;
			#80;
			host_clock_line = 1'b0;
		end
	endtask
	// clock stays low; starting low guarantees three clean rises
	task automatic strobe();
		host_data_line = 1'b0;
		#80;
		repeat (3) begin
			host_data_line = 1'b1;
			#80;
			host_data_line = 1'b0;
			#80;
		end
		#160;
	endtask
endmodule // bridge_host_model

// *** bench/sync_serial_bridge_port_bench.sv ***
// Purpose: self-checking bench for the bridge port
// Assumes: conversion period shortened to 50 cycles
// Notes:   converter results are pulsed by the bench
`timescale 1ns/1ns
module sync_serial_bridge_port_bench;
	import bridge_port_pkg::*;
	localparam int unsigned CONV_PERIOD_CYCLES = 50;
	logic        clock, sys_rst, host_clock_line, host_data_line, instrument_data_line;
	logic        result_ready_line, conversion_start, result_valid, config_update;
	logic [3:0]  device_select_address;
	logic [23:0] result_bcd, panel_indicators;
	logic [47:0] applied_config, rx, last_cfg;
	int          errors, samples_checked;
	sync_serial_bridge_port #(.CONV_PERIOD_CYCLES(CONV_PERIOD_CYCLES)) sync_serial_bridge_port_inst (
		.clock(clock), .sys_rst(sys_rst), .host_clock_line(host_clock_line),
		.host_data_line(host_data_line), .instrument_data_line(instrument_data_line),
		.result_ready_line(result_ready_line), .device_select_address(device_select_address),
		.conversion_start(conversion_start), .result_valid(result_valid),
		.result_bcd(result_bcd), .panel_indicators(panel_indicators),
		.applied_config(applied_config), .config_update(config_update));
	bridge_host_model bridge_host_model_inst (.host_clock_line(host_clock_line),
		.host_data_line(host_data_line), .instrument_data_line(instrument_data_line));
	task automatic tick();
		@(posedge clock);
		#2;
	endtask
	task automatic check(input logic ok, input string what);
		samples_checked++;
		if (ok !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic new_result(input logic [23:0] bcd);
		check(result_ready_line === 1'b0, "ready high before result");
		result_bcd = bcd;
		result_valid = 1'b1;
		tick();
		result_valid = 1'b0;
		tick();
		check(result_ready_line === 1'b1, "ready not set");
	endtask
	// ****
	// scenarios
	// ****
	task automatic test_match();
		logic [3:0] sw [3] = '{4'h5, 4'h0, 4'hf};
		logic [7:0] ad [3] = '{8'h05, 8'h01, 8'h0f};
		logic [47:0] cfg;
		for (int k = 0; k < 3; k++) begin
			device_select_address = sw[k];
			panel_indicators = 24'h5a0f30 + 24'(k);
			cfg = 48'ha5c3_0f1e_7701 ^ 48'(k);
			new_result(24'h123456 + 24'(k));
			bridge_host_model_inst.shift(48'(ad[k]), 8, rx);
			bridge_host_model_inst.strobe();
			bridge_host_model_inst.shift(cfg, 48, rx);
			check(applied_config === last_cfg, "config applied early");
			check(rx === {24'h5a0f30 + 24'(k), 24'h123456 + 24'(k)}, "response");
			bridge_host_model_inst.strobe();
			check(applied_config === cfg, "config not applied");
			check(result_ready_line === 1'b0, "ready not cleared");
			check(instrument_data_line === 1'b0, "data line after close");
			last_cfg = cfg;
		end
		$display("test_match done");
	endtask
	task automatic test_other();
		device_select_address = 4'h5;
		new_result(24'h987654);
		bridge_host_model_inst.shift(48'hffff_ffff_ffff, 48, rx);
		check(rx === 48'h0, "closed port answered");
		bridge_host_model_inst.shift(48'h03, 8, rx);
		bridge_host_model_inst.strobe();
		bridge_host_model_inst.shift(48'hffff_ffff_ffff, 48, rx);
		check(rx === 48'h0, "other address answered");
		bridge_host_model_inst.strobe();
		check(applied_config === last_cfg, "other address applied");
		check(result_ready_line === 1'b1, "ready cleared by other");
		$display("test_other done");
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		$display("unexpected at %0t: watchdog", $time);
		stop_test();
	end
	initial begin
		sys_rst = 1'b1;
		result_valid = 1'b0;
		result_bcd = 24'h0;
		panel_indicators = 24'h0;
		device_select_address = 4'h5;
		last_cfg = CONFIG_RESET;
		repeat (20) @(posedge clock);
		#2;
		sys_rst = 1'b0;
		repeat (4) tick();
		check(instrument_data_line === 1'b0, "data line after reset");
		check(result_ready_line === 1'b0, "ready after reset");
		check(applied_config === CONFIG_RESET, "config after reset");
		test_match();
		test_other();
		stop_test();
	end
endmodule // sync_serial_bridge_port_bench
bind sync_serial_bridge_port bridge_port_sva #(.CONV_PERIOD_CYCLES(CONV_PERIOD_CYCLES)) sva_inst (
	.clock(clock), .sys_rst(sys_rst), .host_clock_line(host_clock_line),
	.host_data_line(host_data_line), .instrument_data_line(instrument_data_line),
	.result_ready_line(result_ready_line), .device_select_address(device_select_address),
	.conversion_start(conversion_start), .result_valid(result_valid), .result_bcd(result_bcd),
	.panel_indicators(panel_indicators), .applied_config(applied_config),
	.config_update(config_update));
